//--- verilog/supply_cfg_pkg.sv
// constants and register layout of the supply protection configuration registers
// Operation
// - power-up loads registers from eeprom shadow
// - trim lock blocks all register writes, including config four itself
// - current-limit mask hides overcurrent, flag stays
// - config five bit 6: enable polarity
// - config five bit 5: breaker polarity
// - config five bit 2: short ride-through
// - config five bit 1: ground input masked
// - config five bit 0: breaker latch mode
// - restart bit: latch off or auto-restart
// - ride-through field selects period, four codes
package supply_cfg_pkg;
  // ==========================================================
  // register offsets and eeprom shadow addresses
  localparam logic [7:0]  OFS_CFG4    = 8'h10;
  localparam logic [7:0]  OFS_CFG5    = 8'h11;
  localparam logic [7:0]  OFS_CFG6    = 8'h12;
  localparam logic [15:0] EE_CFG4     = 16'h8110;
  localparam logic [15:0] EE_CFG5     = 16'h8111;
  localparam logic [15:0] EE_CFG6     = 16'h8112;
  // ==========================================================
  // field positions
  localparam int B_TRIM_LOCK  = 0;
  localparam int B_CL_MASK    = 7;
  localparam int B_PEN_POL    = 6;
  localparam int B_CB_POL     = 5;
  localparam int B_SHORT_RT   = 2;
  localparam int B_GND_DIS    = 1;
  localparam int B_CB_LATCH   = 0;
  localparam int B_RESTART    = 7;
  localparam int B_RT_HI      = 4;
  localparam int B_RT_LO      = 3;
  localparam int B_CLAMP_THR  = 0;
  // ==========================================================
  // timing, clock 125 mhz
  localparam int CLK_MHZ      = 125;
  localparam int RT_SHORT_US  = 128;
  localparam int RT_LONG_MS   = 1000;
  localparam int RESTART_MS   = 1000;
  localparam int RT_SHORT_CYC = RT_SHORT_US * CLK_MHZ;
  localparam int RT_LONG_CYC  = RT_LONG_MS * 1000 * CLK_MHZ;
  localparam int RESTART_CYC  = RESTART_MS * 1000 * CLK_MHZ;
  localparam int RESIDUAL_CYC = 2;
  localparam logic [6:0] CLAMP_75 = 7'h4b;
  localparam logic [6:0] CLAMP_88 = 7'h58;
  localparam int EE_STEPS     = 3;
  // ==========================================================
  // protection state
  typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_LATCHED, ST_WAIT} prot_state_t;
endpackage : supply_cfg_pkg

//--- verilog/cfg_bus_if.sv
// interface carrying configuration fields to the fault logic
interface cfg_bus_if;
  logic       cl_mask;
  logic       short_rt;
  logic       restart;
  logic [1:0] rt_code;
  logic       cb_latch;
  logic       loaded;
  modport src (output cl_mask, output short_rt, output restart, output rt_code,
               output cb_latch, output loaded);
  modport dst (input cl_mask, input short_rt, input restart, input rt_code,
               input cb_latch, input loaded);
endinterface : cfg_bus_if

//--- verilog/supply_fault_ctrl.sv
// fault sequencer: ride-through, latch-off and auto-restart
module supply_fault_ctrl #(
  parameter int RT_LONG_CYC = supply_cfg_pkg::RT_LONG_CYC,
  parameter int RESTART_CYC = supply_cfg_pkg::RESTART_CYC
) (
  input  wire logic i_clock,
  input  wire logic i_rst,
  cfg_bus_if.dst    cfg,
  input  wire logic i_oc,
  input  wire logic i_uv,
  input  wire logic i_ps_on,
  output logic      o_fault_off,
  output logic      o_oc_trip
);
  supply_cfg_pkg::prot_state_t st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic        ps_on_q, ps_on_d;
  logic [31:0] rt_lim;
  logic        oc_gen;

  always_comb
  begin
    oc_gen = i_oc & ~cfg.cl_mask;
    if (cfg.short_rt)
      rt_lim = 32'(supply_cfg_pkg::RT_SHORT_CYC) * 32'({30'h0, cfg.rt_code} + 32'h1)
               + 32'(supply_cfg_pkg::RESIDUAL_CYC);
    else
      rt_lim = 32'(RT_LONG_CYC) * 32'({30'h0, cfg.rt_code} + 32'h1);
  end

  always_comb
  begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    ps_on_d = i_ps_on;
    case (st_q)
      supply_cfg_pkg::ST_LOAD:
        if (cfg.loaded)
          st_d = supply_cfg_pkg::ST_RUN;
      supply_cfg_pkg::ST_RUN:
      begin
        if (i_uv)
        begin
          st_d  = cfg.restart ? supply_cfg_pkg::ST_WAIT : supply_cfg_pkg::ST_LATCHED;
          cnt_d = 32'h0;
        end
        else if (oc_gen)
        begin
          cnt_d = cnt_q + 32'h1;
          if (cnt_q >= rt_lim)
          begin
            st_d  = cfg.restart ? supply_cfg_pkg::ST_WAIT : supply_cfg_pkg::ST_LATCHED;
            cnt_d = 32'h0;
          end
        end
        else
          cnt_d = 32'h0;
      end
      supply_cfg_pkg::ST_LATCHED:
        if (ps_on_q && !i_ps_on)
          st_d = supply_cfg_pkg::ST_RUN;
      supply_cfg_pkg::ST_WAIT:
      begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q >= 32'(RESTART_CYC - 1))
        begin
          st_d  = supply_cfg_pkg::ST_RUN;
          cnt_d = 32'h0;
        end
      end
      default:
        st_d = supply_cfg_pkg::ST_LOAD;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      st_q    <= supply_cfg_pkg::ST_LOAD;
      cnt_q   <= 32'h0;
      ps_on_q <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      ps_on_q <= ps_on_d;
    end
  end

  assign o_fault_off = (st_q != supply_cfg_pkg::ST_RUN);
  assign o_oc_trip   = oc_gen;
endmodule : supply_fault_ctrl

//--- verilog/supply_protection_config_regs.sv
// register bank and output stage of the supply protection configuration
module supply_protection_config_regs #(
  parameter int RT_LONG_CYC = supply_cfg_pkg::RT_LONG_CYC,
  parameter int RESTART_CYC = supply_cfg_pkg::RESTART_CYC
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_wr_en,
  input  wire logic [7:0]  i_wr_addr,
  input  wire logic [7:0]  i_wr_data,
  input  wire logic [7:0]  i_rd_addr,
  output logic      [7:0]  o_rd_data,
  output logic             o_ee_req,
  output logic      [15:0] o_ee_addr,
  input  wire logic [7:0]  i_ee_data,
  input  wire logic        i_ee_valid,
  input  wire logic        i_overcurrent_fault,
  input  wire logic        i_undervoltage_fault,
  input  wire logic        i_ps_on,
  input  wire logic        i_ground_ok,
  input  wire logic        i_breaker_fault,
  output logic             o_power_enable_output,
  output logic             o_breaker_output,
  output logic             o_overcurrent_flag,
  output logic             o_ground_ok_filtered,
  output logic      [6:0]  o_clamp_release_pct,
  output logic             o_write_rejected,
  output logic             o_loaded
);
  // ==========================================================
  // registers
  logic [7:0]  cfg4_q;
  logic [7:0]  cfg4_d;
  logic [7:0]  cfg5_q;
  logic [7:0]  cfg5_d;
  logic [7:0]  cfg6_q;
  logic [7:0]  cfg6_d;
  logic [1:0]  step_q;
  logic [1:0]  step_d;
  logic        load_q;
  logic        load_d;
  logic        cb_q;
  logic        cb_d;
  logic        ocf_q;
  logic        ocf_d;
  logic        pen_q;
  logic        pen_d;
  logic        cbo_q;
  logic        cbo_d;
  logic        gnd_q;
  logic        gnd_d;
  logic        rej_q;
  logic        rej_d;
  logic        req_q;
  logic        req_d;
  logic [15:0] eaddr_q;
  logic [15:0] eaddr_d;
  logic [6:0]  clamp_q;
  logic [6:0]  clamp_d;
  logic [7:0]  rd_q;
  logic [7:0]  rd_d;
  logic        fault_off;
  logic        oc_trip;

  // ==========================================================
  // configuration fields to the fault sequencer
  cfg_bus_if cfg ();
  assign cfg.cl_mask  = cfg5_q[supply_cfg_pkg::B_CL_MASK];
  assign cfg.short_rt = cfg5_q[supply_cfg_pkg::B_SHORT_RT];
  assign cfg.restart  = cfg6_q[supply_cfg_pkg::B_RESTART];
  assign cfg.rt_code  = cfg6_q[supply_cfg_pkg::B_RT_HI:supply_cfg_pkg::B_RT_LO];
  assign cfg.cb_latch = cfg5_q[supply_cfg_pkg::B_CB_LATCH];
  assign cfg.loaded   = load_q;

  // ==========================================================
  // fault sequencer
  supply_fault_ctrl #(
    .RT_LONG_CYC (RT_LONG_CYC),
    .RESTART_CYC (RESTART_CYC)
  ) u_fault (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .cfg         (cfg.dst),
    .i_oc        (i_overcurrent_fault),
    .i_uv        (i_undervoltage_fault),
    .i_ps_on     (i_ps_on),
    .o_fault_off (fault_off),
    .o_oc_trip   (oc_trip)
  );

  // ==========================================================
  // eeprom shadow address per load step
  function automatic logic [15:0] ee_addr_of(input logic [1:0] s);
    case (s)
      2'h0:    ee_addr_of = supply_cfg_pkg::EE_CFG4;
      2'h1:    ee_addr_of = supply_cfg_pkg::EE_CFG5;
      default: ee_addr_of = supply_cfg_pkg::EE_CFG6;
    endcase
  endfunction : ee_addr_of

  // ==========================================================
  // eeprom load and register writes
  always_comb
  begin
    cfg4_d  = cfg4_q;
    cfg5_d  = cfg5_q;
    cfg6_d  = cfg6_q;
    step_d  = step_q;
    load_d  = load_q;
    req_d   = 1'b0;
    rej_d   = 1'b0;
    eaddr_d = ee_addr_of(step_q);
    if (!load_q)
    begin
      req_d = 1'b1;
      if (i_ee_valid)
      begin
        case (step_q)
          2'h0:    cfg4_d = i_ee_data;
          2'h1:    cfg5_d = i_ee_data;
          default: cfg6_d = i_ee_data;
        endcase
        req_d  = 1'b0;
        step_d = step_q + 2'h1;
        if (32'(step_q) == supply_cfg_pkg::EE_STEPS - 1)
          load_d = 1'b1;
      end
    end
    else if (i_wr_en)
    begin
      // lock refuses the whole bank
      if (cfg4_q[supply_cfg_pkg::B_TRIM_LOCK])
        rej_d = 1'b1;
      else
      begin
        case (i_wr_addr)
          supply_cfg_pkg::OFS_CFG4: cfg4_d = i_wr_data;
          supply_cfg_pkg::OFS_CFG5: cfg5_d = i_wr_data;
          supply_cfg_pkg::OFS_CFG6: cfg6_d = i_wr_data;
          default:                  rej_d  = 1'b1;
        endcase
      end
    end
  end

  // ==========================================================
  // outputs and status
  always_comb
  begin
    ocf_d = ocf_q | i_overcurrent_fault;
    if (!cfg.cb_latch)
      cb_d = i_breaker_fault | oc_trip;
    else
      cb_d = cb_q | i_breaker_fault | oc_trip;
    pen_d = ~fault_off ^ ~cfg5_q[supply_cfg_pkg::B_PEN_POL];
    cbo_d = cb_d ^ ~cfg5_q[supply_cfg_pkg::B_CB_POL];
    gnd_d = cfg5_q[supply_cfg_pkg::B_GND_DIS] ? 1'b1 : i_ground_ok;
    clamp_d = cfg6_q[supply_cfg_pkg::B_CLAMP_THR] ? supply_cfg_pkg::CLAMP_88
                                                  : supply_cfg_pkg::CLAMP_75;
    // read-back mux
    case (i_rd_addr)
      supply_cfg_pkg::OFS_CFG4: rd_d = cfg4_q;
      supply_cfg_pkg::OFS_CFG5: rd_d = cfg5_q;
      supply_cfg_pkg::OFS_CFG6: rd_d = cfg6_q;
      default:                  rd_d = 8'h00;
    endcase
  end

  // ==========================================================
  // state registers
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      cfg4_q  <= 8'h00;
      cfg5_q  <= 8'h00;
      cfg6_q  <= 8'h00;
      step_q  <= 2'h0;
      load_q  <= 1'b0;
      req_q   <= 1'b0;
      rej_q   <= 1'b0;
      eaddr_q <= 16'h0000;
      cb_q    <= 1'b0;
      ocf_q   <= 1'b0;
      pen_q   <= 1'b0;
      cbo_q   <= 1'b0;
      gnd_q   <= 1'b0;
      clamp_q <= 7'h00;
      rd_q    <= 8'h00;
    end
    else
    begin
      cfg4_q  <= cfg4_d;
      cfg5_q  <= cfg5_d;
      cfg6_q  <= cfg6_d;
      step_q  <= step_d;
      load_q  <= load_d;
      req_q   <= req_d;
      rej_q   <= rej_d;
      eaddr_q <= eaddr_d;
      cb_q    <= cb_d;
      ocf_q   <= ocf_d;
      pen_q   <= pen_d;
      cbo_q   <= cbo_d;
      gnd_q   <= gnd_d;
      clamp_q <= clamp_d;
      rd_q    <= rd_d;
    end
  end

  // ==========================================================
  // output ports
  assign o_rd_data             = rd_q;
  assign o_ee_req              = req_q;
  assign o_ee_addr             = eaddr_q;
  assign o_power_enable_output = pen_q;
  assign o_breaker_output      = cbo_q;
  assign o_overcurrent_flag    = ocf_q;
  assign o_ground_ok_filtered  = gnd_q;
  assign o_clamp_release_pct   = clamp_q;
  assign o_write_rejected      = rej_q;
  assign o_loaded              = load_q;
endmodule : supply_protection_config_regs

//--- tb/supply_ee_model.sv
// eeprom shadow model answering the register load requests
module supply_ee_model (
  input  wire logic        i_clock,
  input  wire logic        i_req,
  input  wire logic [15:0] i_addr,
  input  wire logic [23:0] i_words,
  input  wire logic        i_slow,
  output logic             o_valid,
  output logic      [7:0]  o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q = 4'h0;
  initial o_valid = 1'b0;
  initial o_data = 8'h00;
  // ==========================================================
  // answer after a short or long wait, toggle the data otherwise
  always @(negedge i_clock)
  begin
    if (i_req && wait_q >= (i_slow ? 4'h9 : 4'h2))
    begin
      o_valid <= 1'b1;
      o_data  <= i_words[8 * i_addr[1:0] +: 8];
      wait_q  <= 4'h0;
    end
    else
    begin
      o_valid <= 1'b0;
      o_data  <= ~o_data;
      wait_q  <= i_req ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule : supply_ee_model

//--- tb/supply_cfg_monitor.sv
// assertions on the configuration register bank ports
module supply_cfg_monitor (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic        i_wr_en,
  input wire logic [7:0]  i_wr_addr,
  input wire logic [15:0] o_ee_addr,
  input wire logic        i_ee_valid,
  input wire logic        i_overcurrent_fault,
  input wire logic        o_overcurrent_flag,
  input wire logic [6:0]  o_clamp_release_pct,
  input wire logic        o_write_rejected,
  input wire logic        o_loaded
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // ==========================================================
  // load, write refusal, flag and clamp relations
  ee_step_a: assert property (i_ee_valid && !o_loaded && o_ee_addr != 16'h8112
    |-> ##2 o_ee_addr == $past(o_ee_addr, 2) + 16'h1) else $error("eeprom address did not step");
  load_done_a: assert property (i_ee_valid && !o_loaded && o_ee_addr == 16'h8112
    |=> o_loaded) else $error("load not done after third word");
  loaded_hold_a: assert property (o_loaded |=> o_loaded)
    else $error("loaded flag dropped");
  oc_flag_a: assert property (i_overcurrent_fault |=> o_overcurrent_flag)
    else $error("overcurrent flag not set");
  flag_hold_a: assert property (o_overcurrent_flag |=> o_overcurrent_flag)
    else $error("overcurrent flag cleared");
  bad_addr_a: assert property (i_wr_en && o_loaded && !(i_wr_addr inside {[8'h10:8'h12]})
    |=> o_write_rejected) else $error("unmapped write not refused");
  reject_cause_a: assert property (o_write_rejected |-> $past(i_wr_en && o_loaded))
    else $error("refusal without a write");
  clamp_val_a: assert property ($past(o_loaded) |-> o_clamp_release_pct inside {7'h4b, 7'h58})
    else $error("clamp threshold not 75 or 88");
endmodule : supply_cfg_monitor
bind supply_protection_config_regs supply_cfg_monitor u_mon (.i_clock(i_clock), .i_rst(i_rst),
  .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr), .o_ee_addr(o_ee_addr), .i_ee_valid(i_ee_valid),
  .i_overcurrent_fault(i_overcurrent_fault), .o_overcurrent_flag(o_overcurrent_flag),
  .o_clamp_release_pct(o_clamp_release_pct), .o_write_rejected(o_write_rejected),
  .o_loaded(o_loaded));

//--- tb/supply_protection_config_regs_tb_top.sv
// self-checking bench of the supply configuration registers
module supply_protection_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, wr_en = 1'b0, valid, oc = 1'b0, uv = 1'b0;
  logic        gnd = 1'b0, brk = 1'b0, slow = 1'b0, ps_on = 1'b1;
  logic        ee_req, power_enable_output, brk_out, oc_flag, gnd_f, rej, loaded;
  logic [7:0]  wr_addr = 8'h00, wr_data = 8'h00, rd_addr = 8'h00, rd_data, ee_data;
  logic [15:0] ee_addr;
  logic [23:0] words = 24'h0;
  logic [6:0]  clamp;
  logic [7:0]  cfg [3];
  logic [31:0] seed = 32'he12d2af1;
  int          bad_count = 0, compares = 0;
  initial forever #4 clk = ~clk;
  supply_protection_config_regs #(.RT_LONG_CYC(200), .RESTART_CYC(100)) DUT (.i_clock(clk),
    .i_rst(rst), .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
    .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_ee_req(ee_req), .o_ee_addr(ee_addr),
    .i_ee_data(ee_data), .i_ee_valid(valid), .i_overcurrent_fault(oc),
    .i_undervoltage_fault(uv), .i_ps_on(ps_on), .i_ground_ok(gnd), .i_breaker_fault(brk),
    .o_power_enable_output(power_enable_output), .o_breaker_output(brk_out), .o_overcurrent_flag(oc_flag),
    .o_ground_ok_filtered(gnd_f), .o_clamp_release_pct(clamp), .o_write_rejected(rej),
    .o_loaded(loaded));
  supply_ee_model u_ee (.i_clock(clk), .i_req(ee_req), .i_addr(ee_addr), .i_words(words),
    .i_slow(slow), .o_valid(valid), .o_data(ee_data));
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [6:0] exp_clamp(input logic [7:0] c);
    return c[0] ? 7'h58 : 7'h4b;
  endfunction : exp_clamp
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic r);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk);
    wr_en = 1'b0;
    check(rej, r);
    if (!r)
      cfg[a[1:0]] = d;
    repeat (2) @(negedge clk);
  endtask : wr
  task automatic rd_all;
    for (int i = 0; i < 3; i++)
    begin
      rd_addr = 8'h10 + 8'(i);
      repeat (2) @(negedge clk);
      check(rd_data, cfg[i]);
    end
  endtask : rd_all
  task automatic boot(input logic [23:0] w, input logic s);
    words = w;
    slow = s;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (int n = 0; n < 100 && loaded !== 1'b1; n++)
      @(negedge clk);
    check(loaded, 1'b1);
    for (int i = 0; i < 3; i++)
      cfg[i] = w[8 * i +: 8];
    rd_all();
  endtask : boot
  // ==========================================================
  // scenarios
  initial
  begin
    boot(24'h5a3c00 ^ {16'h0, 8'hfe & seed[7:0]}, 1'b0);
    for (int k = 0; k < 9; k++)
    begin
      seed = xs(seed);
      gnd = seed[9];
      wr(8'h10 + 8'(k % 3), seed[7:0] & (k % 3 == 0 ? 8'hfe : 8'hff), 1'b0);
      rd_all();
      check(clamp, exp_clamp(cfg[2]));
      check(gnd_f, cfg[1][1] | gnd);
    end
    wr(8'h13, 8'h55, 1'b1);
    wr(8'h12, 8'h00, 1'b0);
    wr(8'h11, 8'h40, 1'b0);
    check(power_enable_output, 1'b1);
    wr(8'h11, 8'h00, 1'b0);
    check(power_enable_output, 1'b0);
    brk = 1'b1;
    wr(8'h11, 8'h20, 1'b0);
    check(brk_out, 1'b1);
    brk = 1'b0;
    repeat (3) @(negedge clk);
    check(brk_out, 1'b0);
    wr(8'h11, 8'h00, 1'b0);
    check(brk_out, 1'b1);
    wr(8'h11, 8'ha0, 1'b0);
    oc = 1'b1;
    repeat (3) @(negedge clk);
    check(brk_out, 1'b0);
    check(oc_flag, 1'b1);
    wr(8'h12, 8'h88, 1'b0);
    wr(8'h11, 8'h60, 1'b0);
    check(brk_out, 1'b1);
    repeat (300) @(negedge clk);
    check(power_enable_output, 1'b1);
    repeat (150) @(negedge clk);
    check(power_enable_output, 1'b0);
    oc = 1'b0;
    repeat (150) @(negedge clk);
    check(power_enable_output, 1'b1);
    wr(8'h12, 8'h00, 1'b0);
    uv = 1'b1;
    repeat (2) @(negedge clk);
    uv = 1'b0;
    repeat (200) @(negedge clk);
    check(power_enable_output, 1'b0);
    ps_on = 1'b0;
    repeat (3) @(negedge clk);
    check(power_enable_output, 1'b1);
    ps_on = 1'b1;
    wr(8'h11, 8'h61, 1'b0);
    brk = 1'b1;
    repeat (2) @(negedge clk);
    brk = 1'b0;
    repeat (3) @(negedge clk);
    check(brk_out, 1'b1);
    wr(8'h10, cfg[0] | 8'h01, 1'b0);
    wr(8'h11, 8'h3c, 1'b1);
    wr(8'h10, 8'h00, 1'b1);
    rd_all();
    boot(24'h123401, 1'b1);
    wr(8'h12, 8'h77, 1'b1);
    boot(24'h123400, 1'b1);
    wr(8'h12, 8'h77, 1'b0);
    rd_all();
    wr(8'h11, 8'h44, 1'b0);
    wr(8'h12, 8'h80, 1'b0);
    oc = 1'b1;
    repeat (15990) @(negedge clk);
    check(power_enable_output, 1'b1);
    repeat (20) @(negedge clk);
    check(power_enable_output, 1'b0);
    oc = 1'b0;
    give_verdict();
  end
  initial
  begin
    #400000;
    bad_count++;
    give_verdict();
  end
endmodule : supply_protection_config_regs_tb_top
